//--- common/dtx_params.svh
// Constants for the delayed transaction ordering bridge and its far end
`ifndef DTX_PARAMS_SVH
`define DTX_PARAMS_SVH
`define DTX_ADDR_W 32
`define DTX_DATA_W 32
`define DTX_BE_W 4
`define DTX_NSLOT 4
`define DTX_PMW_DEPTH 4
`define DTX_DISCARD_CLKS 32768
`define DTX_TGT_LAT 2
`define DTX_MEM_WORDS 256
`endif

//--- common/dtx_pkg.sv
// Types shared by the bridge and its far end
package dtx_pkg;
  typedef enum logic [3:0] {
    CMD_IO_RD = 4'h2,
    CMD_IO_WR = 4'h3,
    CMD_MEM_RD = 4'h6,
    CMD_MEM_WR = 4'h7,
    CMD_CFG_RD = 4'hA,
    CMD_CFG_WR = 4'hB,
    CMD_MEM_RD_MULT = 4'hC,
    CMD_MEM_RD_LINE = 4'hE,
    CMD_MEM_WR_INV = 4'hF
  } dtx_cmd_t;
  typedef enum logic [1:0] {
    RSP_DONE = 2'b00,
    RSP_RETRY = 2'b01,
    RSP_MABORT = 2'b10,
    RSP_TABORT = 2'b11
  } dtx_resp_t;
  typedef enum logic [1:0] {
    SLOT_FREE = 2'b00,
    SLOT_LATCHED = 2'b01,
    SLOT_ATTEMPTED = 2'b10,
    SLOT_HELD = 2'b11
  } dtx_slot_t;
  typedef enum logic [1:0] {
    MST_IDLE = 2'b00,
    MST_REQ = 2'b01,
    MST_GAP = 2'b10
  } dtx_mst_t;
endpackage : dtx_pkg

//--- common/dtx_if.sv
// Originating and destination bus signals between bridge and far end
`timescale 1ns/1ps
`default_nettype none
interface dtx_if #(
  parameter int AW = 32,
  parameter int DW = 32,
  parameter int BW = 4
);
  // Originating bus: master request, bridge answer
  logic orig_req;
  logic [3:0] orig_cmd;
  logic [AW-1:0] orig_addr;
  logic [BW-1:0] orig_be;
  logic [DW-1:0] orig_wdata;
  logic orig_ack;
  logic [1:0] orig_resp;
  logic [DW-1:0] orig_rdata;
  // Destination bus: bridge request, target answer
  logic dst_req;
  logic dst_posted;
  logic [3:0] dst_cmd;
  logic [AW-1:0] dst_addr;
  logic [BW-1:0] dst_be;
  logic [DW-1:0] dst_wdata;
  logic dst_ack;
  logic [1:0] dst_resp;
  logic [DW-1:0] dst_rdata;

  modport bridge (
    input orig_req, orig_cmd, orig_addr, orig_be, orig_wdata,
    output orig_ack, orig_resp, orig_rdata,
    output dst_req, dst_posted, dst_cmd, dst_addr, dst_be, dst_wdata,
    input dst_ack, dst_resp, dst_rdata
  );
  modport far (
    output orig_req, orig_cmd, orig_addr, orig_be, orig_wdata,
    input orig_ack, orig_resp, orig_rdata,
    input dst_req, dst_posted, dst_cmd, dst_addr, dst_be, dst_wdata,
    output dst_ack, dst_resp, dst_rdata
  );
endinterface : dtx_if
`default_nettype wire

//--- src/dtx_far_end.sv
// Far end: repeating master on the originating bus, memory target on the destination bus
`timescale 1ns/1ps
`default_nettype none
`include "dtx_params.svh"
module dtx_far_end #(
  parameter int AW = `DTX_ADDR_W,
  parameter int DW = `DTX_DATA_W,
  parameter int BW = `DTX_BE_W,
  parameter int MEM_WORDS = `DTX_MEM_WORDS,
  parameter int TGT_LAT = `DTX_TGT_LAT
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Bus side
  dtx_if.far bus,
  // Master command port
  input wire logic mst_req_i,
  input wire logic [3:0] mst_cmd_i,
  input wire logic [AW-1:0] mst_addr_i,
  input wire logic [BW-1:0] mst_be_i,
  input wire logic [DW-1:0] mst_wdata_i,
  output logic mst_busy_o,
  output logic mst_done_o,
  output logic [1:0] mst_resp_o,
  output logic [DW-1:0] mst_rdata_o,
  // Target behaviour controls
  input wire logic tgt_retry_i,
  input wire logic tgt_abort_i
);
  localparam int MW = (MEM_WORDS > 1) ? $clog2(MEM_WORDS) : 1;
  localparam int LW = (TGT_LAT > 1) ? $clog2(TGT_LAT) + 1 : 1;

  dtx_pkg::dtx_mst_t mst_state_reg;
  logic [DW-1:0] mem [MEM_WORDS];
  logic [LW-1:0] lat_cnt_reg;
  logic [MW-1:0] word_idx;
  logic tgt_fire;

  assign word_idx = bus.dst_addr[MW+1:2];
  assign tgt_fire = bus.dst_req && !bus.dst_ack && (lat_cnt_reg == LW'(TGT_LAT - 1));

  // Master: one transaction at a time, repeated until it completes
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mst_state_reg <= dtx_pkg::MST_IDLE;
      bus.orig_req <= 1'b0;
      bus.orig_cmd <= 4'h0;
      mst_busy_o <= 1'b0;
      bus.orig_addr <= '0;
      bus.orig_be <= '0;
      bus.orig_wdata <= '0;
      mst_done_o <= 1'b0;
      mst_resp_o <= 2'b00;
      mst_rdata_o <= '0;
    end else begin
      mst_done_o <= 1'b0;
      unique case (mst_state_reg)
        dtx_pkg::MST_IDLE: begin
          if (mst_req_i) begin
            bus.orig_req <= 1'b1;
            bus.orig_cmd <= mst_cmd_i;
            bus.orig_addr <= mst_addr_i;
            bus.orig_be <= mst_be_i;
            bus.orig_wdata <= mst_wdata_i;
            mst_busy_o <= 1'b1; // Busy from the edge that takes the request
            mst_state_reg <= dtx_pkg::MST_REQ;
          end
        end
        dtx_pkg::MST_REQ: begin
          if (bus.orig_ack) begin
            bus.orig_req <= 1'b0;
            if (bus.orig_resp == dtx_pkg::RSP_RETRY) begin
              mst_state_reg <= dtx_pkg::MST_GAP; // Still only a request
            end else begin
              mst_done_o <= 1'b1; // Data moved or abort: complete
              mst_resp_o <= bus.orig_resp;
              mst_rdata_o <= bus.orig_rdata;
              mst_busy_o <= 1'b0;
              mst_state_reg <= dtx_pkg::MST_IDLE;
            end
          end
        end
        dtx_pkg::MST_GAP: begin
          bus.orig_req <= 1'b1; // Same transaction issued again
          mst_state_reg <= dtx_pkg::MST_REQ;
        end
        default: begin
          bus.orig_req <= 1'b0;
          mst_busy_o <= 1'b0;
          mst_state_reg <= dtx_pkg::MST_IDLE;
        end
      endcase
    end
  end

  // Target latency counter
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lat_cnt_reg <= '0;
    end else if (!bus.dst_req || bus.dst_ack || tgt_fire) begin
      lat_cnt_reg <= '0;
    end else begin
      lat_cnt_reg <= lat_cnt_reg + LW'(1);
    end
  end

  // Target answer
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus.dst_ack <= 1'b0;
      bus.dst_resp <= 2'b00;
      bus.dst_rdata <= '0;
    end else begin
      bus.dst_ack <= tgt_fire;
      if (tgt_fire) begin
        bus.dst_rdata <= mem[word_idx];
        if (tgt_retry_i) begin
          bus.dst_resp <= dtx_pkg::RSP_RETRY;
        end else if (tgt_abort_i) begin
          bus.dst_resp <= dtx_pkg::RSP_TABORT;
        end else begin
          bus.dst_resp <= dtx_pkg::RSP_DONE;
        end
      end
    end
  end

  // Target memory, byte-lane writes on normal completion
  always_ff @(posedge sys_clk_i) begin
    if (tgt_fire && !tgt_retry_i && !tgt_abort_i && bus.dst_cmd[0]) begin
      for (int b = 0; b < BW; b++) begin
        if (bus.dst_be[b]) begin
          mem[word_idx][b*8 +: 8] <= bus.dst_wdata[b*8 +: 8];
        end
      end
    end
  end
endmodule : dtx_far_end
`default_nettype wire

//--- src/dtx_bridge.sv
// Bridge end: posted write queue and delayed transaction slots
//
// Summary of operation
// - Slot count is a free parameter
// - Only non-posted commands become delayed
// - Retried masters must repeat the same transaction
// - Attempted request keeps retrying until done
// - Held completion dropped only after timeout
// - Memory writes accepted into queue unless it is full, then retried
// - Slots served in any order
// - Posted writes pass all but posted writes
// - Dependent master transactions wait for completion
// - Retry sets no ordering; completion does
// - Complete means data moved or abort
// - Each pending request repeated on its own
// - Phase one: latch request, answer retry
// - Phase two: execute, hold status and data
// - Phase three: return completion, free slot
// - Memory write commands are always posted
// - Read commands are delayed read requests
// - I/O and config writes are delayed
// - Same-agent requests carry no mutual order
// - Posted writes leave in arrival order
// - Delayed requests, read completions wait writes
// - Completions pass queued delayed requests
// - Posted writes pass blocking completions
`timescale 1ns/1ps
`default_nettype none
`include "dtx_params.svh"
module dtx_bridge #(
  parameter int AW = `DTX_ADDR_W,
  parameter int DW = `DTX_DATA_W,
  parameter int BW = `DTX_BE_W,
  parameter int NSLOT = `DTX_NSLOT,
  parameter int PMW_DEPTH = `DTX_PMW_DEPTH,
  parameter int DISCARD_CLKS = `DTX_DISCARD_CLKS
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Bus side
  dtx_if.bridge bus,
  // Status
  output logic [NSLOT-1:0] slot_busy_o,
  output logic discard_o
);
  localparam int SW = (NSLOT > 1) ? $clog2(NSLOT) : 1;
  localparam int QW = (PMW_DEPTH > 1) ? $clog2(PMW_DEPTH) : 1;
  localparam int PW = QW + 1;
  localparam int TW = $clog2(DISCARD_CLKS) + 1;

  // Posted write commands
  function automatic logic is_posted(input logic [3:0] c);
    return (c == dtx_pkg::CMD_MEM_WR) || (c == dtx_pkg::CMD_MEM_WR_INV);
  endfunction : is_posted

  // Delayed read and delayed write commands
  function automatic logic is_delayed(input logic [3:0] c);
    return (c == dtx_pkg::CMD_IO_RD) || (c == dtx_pkg::CMD_CFG_RD) ||
           (c == dtx_pkg::CMD_MEM_RD) || (c == dtx_pkg::CMD_MEM_RD_LINE) ||
           (c == dtx_pkg::CMD_MEM_RD_MULT) ||
           (c == dtx_pkg::CMD_IO_WR) || (c == dtx_pkg::CMD_CFG_WR);
  endfunction : is_delayed

  // Posted write queue
  logic [AW-1:0] pq_addr [PMW_DEPTH];
  logic [BW-1:0] pq_be [PMW_DEPTH];
  logic [DW-1:0] pq_data [PMW_DEPTH];
  logic [3:0] pq_cmd [PMW_DEPTH];
  logic [PW-1:0] pq_wr_reg;
  logic [PW-1:0] pq_rd_reg;
  logic [PW-1:0] pq_count;
  logic pq_full;
  // Delayed transaction slots
  dtx_pkg::dtx_slot_t sl_state [NSLOT];
  logic [3:0] sl_cmd [NSLOT];
  logic [AW-1:0] sl_addr [NSLOT];
  logic [BW-1:0] sl_be [NSLOT];
  logic [DW-1:0] sl_wdata [NSLOT];
  logic [DW-1:0] sl_rdata [NSLOT];
  logic [1:0] sl_resp [NSLOT];
  logic [PW-1:0] sl_pend [NSLOT];
  logic [TW-1:0] sl_timer [NSLOT];
  // Decisions
  logic take;
  logic push;
  logic hit;
  logic [SW-1:0] hit_idx;
  logic free_ok;
  logic [SW-1:0] free_idx;
  logic give_back;
  logic latch_new;
  logic iss_ok;
  logic [SW-1:0] iss_idx;
  logic dst_from_pmw_reg;
  logic [SW-1:0] dst_slot_reg;
  logic pmw_done;
  logic slot_ack;

  assign pq_count = pq_wr_reg - pq_rd_reg;
  assign pq_full = (pq_count == PW'(PMW_DEPTH));
  assign take = bus.orig_req && !bus.orig_ack;
  assign push = take && is_posted(bus.orig_cmd) && !pq_full;
  assign give_back = take && is_delayed(bus.orig_cmd) && hit &&
                     (sl_state[hit_idx] == dtx_pkg::SLOT_HELD) && (sl_pend[hit_idx] == '0);
  assign latch_new = take && is_delayed(bus.orig_cmd) && !hit && free_ok;
  assign pmw_done = bus.dst_ack && dst_from_pmw_reg && (bus.dst_resp != dtx_pkg::RSP_RETRY);
  assign slot_ack = bus.dst_ack && !dst_from_pmw_reg;

  // Slot search: exact match, free slot, issuable request
  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    free_ok = 1'b0;
    free_idx = '0;
    iss_ok = 1'b0;
    iss_idx = '0;
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (sl_state[i] != dtx_pkg::SLOT_FREE && sl_cmd[i] == bus.orig_cmd &&
          sl_addr[i] == bus.orig_addr && sl_be[i] == bus.orig_be &&
          (!sl_cmd[i][0] || sl_wdata[i] == bus.orig_wdata)) begin
        hit = 1'b1;
        hit_idx = SW'(i);
      end
      if (sl_state[i] == dtx_pkg::SLOT_FREE) begin
        free_ok = 1'b1;
        free_idx = SW'(i);
      end
      if ((sl_state[i] == dtx_pkg::SLOT_LATCHED || sl_state[i] == dtx_pkg::SLOT_ATTEMPTED) &&
          sl_pend[i] == '0) begin
        iss_ok = 1'b1;
        iss_idx = SW'(i);
      end
    end
  end

  // Originating bus answer
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus.orig_ack <= 1'b0;
      bus.orig_resp <= 2'b00;
      bus.orig_rdata <= '0;
    end else begin
      bus.orig_ack <= take;
      if (take) begin
        bus.orig_rdata <= '0;
        if (is_posted(bus.orig_cmd)) begin
          bus.orig_resp <= pq_full ? dtx_pkg::RSP_RETRY : dtx_pkg::RSP_DONE;
        end else if (!is_delayed(bus.orig_cmd)) begin
          bus.orig_resp <= dtx_pkg::RSP_MABORT;
        end else if (give_back) begin
          bus.orig_resp <= sl_resp[hit_idx];
          bus.orig_rdata <= sl_rdata[hit_idx];
        end else begin
          bus.orig_resp <= dtx_pkg::RSP_RETRY;
        end
      end
    end
  end

  // Posted write queue storage and pointers
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pq_wr_reg <= '0;
      pq_rd_reg <= '0;
    end else begin
      if (push) begin
        pq_cmd[pq_wr_reg[QW-1:0]] <= bus.orig_cmd;
        pq_addr[pq_wr_reg[QW-1:0]] <= bus.orig_addr;
        pq_be[pq_wr_reg[QW-1:0]] <= bus.orig_be;
        pq_data[pq_wr_reg[QW-1:0]] <= bus.orig_wdata;
        pq_wr_reg <= pq_wr_reg + PW'(1);
      end
      if (pmw_done) begin
        pq_rd_reg <= pq_rd_reg + PW'(1); // Head leaves only when done
      end
    end
  end

  // Destination bus issue: posted head first, then any ready slot
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus.dst_req <= 1'b0;
      bus.dst_posted <= 1'b0;
      bus.dst_cmd <= 4'h0;
      bus.dst_addr <= '0;
      bus.dst_be <= '0;
      bus.dst_wdata <= '0;
      dst_from_pmw_reg <= 1'b0;
      dst_slot_reg <= '0;
    end else if (bus.dst_req) begin
      if (bus.dst_ack) begin
        bus.dst_req <= 1'b0;
      end
    end else if (pq_count != '0) begin
      bus.dst_req <= 1'b1;
      bus.dst_posted <= 1'b1;
      bus.dst_cmd <= pq_cmd[pq_rd_reg[QW-1:0]];
      bus.dst_addr <= pq_addr[pq_rd_reg[QW-1:0]];
      bus.dst_be <= pq_be[pq_rd_reg[QW-1:0]];
      bus.dst_wdata <= pq_data[pq_rd_reg[QW-1:0]];
      dst_from_pmw_reg <= 1'b1;
    end else if (iss_ok) begin
      bus.dst_req <= 1'b1;
      bus.dst_posted <= 1'b0;
      bus.dst_cmd <= sl_cmd[iss_idx];
      bus.dst_addr <= sl_addr[iss_idx];
      bus.dst_be <= sl_be[iss_idx];
      bus.dst_wdata <= sl_wdata[iss_idx];
      dst_from_pmw_reg <= 1'b0;
      dst_slot_reg <= iss_idx;
    end
  end

  // Slot life cycle: latch, attempt, hold, retire or discard
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      discard_o <= 1'b0;
      for (int i = 0; i < NSLOT; i++) begin
        sl_state[i] <= dtx_pkg::SLOT_FREE;
        sl_cmd[i] <= 4'h0;
        sl_addr[i] <= '0;
        sl_be[i] <= '0;
        sl_wdata[i] <= '0;
        sl_rdata[i] <= '0;
        sl_resp[i] <= 2'b00;
        sl_pend[i] <= '0;
        sl_timer[i] <= '0;
      end
    end else begin
      discard_o <= 1'b0;
      for (int i = 0; i < NSLOT; i++) begin
        if (pmw_done && sl_pend[i] != '0) begin
          sl_pend[i] <= sl_pend[i] - PW'(1);
        end
        if (latch_new && free_idx == SW'(i)) begin
          sl_state[i] <= dtx_pkg::SLOT_LATCHED;
          sl_cmd[i] <= bus.orig_cmd;
          sl_addr[i] <= bus.orig_addr;
          sl_be[i] <= bus.orig_be;
          sl_wdata[i] <= bus.orig_wdata;
          sl_pend[i] <= pmw_done ? pq_count - PW'(1) : pq_count;
        end else if (give_back && hit_idx == SW'(i)) begin
          sl_state[i] <= dtx_pkg::SLOT_FREE;
        end else if (slot_ack && dst_slot_reg == SW'(i)) begin
          if (bus.dst_resp == dtx_pkg::RSP_RETRY) begin
            sl_state[i] <= dtx_pkg::SLOT_ATTEMPTED;
          end else begin
            sl_state[i] <= dtx_pkg::SLOT_HELD;
            sl_resp[i] <= bus.dst_resp;
            sl_rdata[i] <= sl_cmd[i][0] ? '0 : bus.dst_rdata;
            sl_timer[i] <= '0;
            // Read completion waits for writes ahead of it; write completion does not
            sl_pend[i] <= sl_cmd[i][0] ? '0 : pq_count;
          end
        end else if (sl_state[i] == dtx_pkg::SLOT_HELD) begin
          if (sl_timer[i] == TW'(DISCARD_CLKS - 1)) begin
            sl_state[i] <= dtx_pkg::SLOT_FREE;
            discard_o <= 1'b1;
          end else begin
            sl_timer[i] <= sl_timer[i] + TW'(1);
          end
        end
      end
    end
  end

  // Busy slot status
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slot_busy_o <= '0;
    end else begin
      for (int i = 0; i < NSLOT; i++) begin
        slot_busy_o[i] <= (sl_state[i] != dtx_pkg::SLOT_FREE);
      end
    end
  end
endmodule : dtx_bridge
`default_nettype wire

//--- dv/dtx_assertions.sv
// Concurrent checks on the bus between bridge and far end
`timescale 1ns/1ps
`default_nettype none
module dtx_assertions #(
  parameter int AW = 32,
  parameter int DW = 32
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Originating bus
  input wire logic orig_req,
  input wire logic [3:0] orig_cmd,
  input wire logic orig_ack,
  input wire logic [1:0] orig_resp,
  input wire logic [DW-1:0] orig_rdata,
  // Destination bus
  input wire logic dst_req,
  input wire logic dst_posted,
  input wire logic [3:0] dst_cmd,
  input wire logic [AW-1:0] dst_addr,
  input wire logic dst_ack,
  input wire logic [1:0] dst_resp
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  // Originating side answers
  a_answer_next_cycle: assert property (orig_req && !orig_ack |=> orig_ack)
    else $error("no answer one cycle after request");
  a_ack_single_pulse: assert property (orig_ack |=> !orig_ack)
    else $error("answer longer than one cycle");
  a_mem_wr_accepted: assert property (orig_req && !orig_ack &&
    (orig_cmd == 4'h7 || orig_cmd == 4'hF) |=> orig_resp inside {2'h0, 2'h1})
    else $error("memory write not posted");
  a_retry_no_data: assert property (orig_ack && orig_resp == 2'h1 |-> orig_rdata == '0)
    else $error("retry carried read data");
  // Destination side commands
  a_posted_mem_only: assert property (dst_req && dst_posted |->
    dst_cmd == 4'h7 || dst_cmd == 4'hF)
    else $error("posted issue with non memory write");
  a_delayed_cmd_set: assert property (dst_req && !dst_posted |->
    dst_cmd inside {4'h2, 4'h3, 4'h6, 4'hA, 4'hB, 4'hC, 4'hE})
    else $error("delayed issue with wrong command");
  a_dst_req_hold: assert property (dst_req && !dst_ack |=>
    dst_req && $stable(dst_addr) && $stable(dst_cmd))
    else $error("destination request changed before answer");
  a_retry_repeats: assert property (dst_ack && dst_resp == 2'h1 |=> ##[1:60] dst_req)
    else $error("retried destination request not repeated");
  a_dst_release: assert property (dst_ack |=> !dst_req)
    else $error("destination request held after answer");
endmodule : dtx_assertions
`default_nettype wire

//--- dv/delayed_transaction_ordering_test.sv
// Self-checking bench joining bridge and far end
`timescale 1ns/1ps
`default_nettype none
`define chk(a, b, m) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch at %0t ns: %s", $time, m); end end
module delayed_transaction_ordering_test;
  logic sys_clk_i, reset_n_i, mst_req_i, tgt_retry_i, tgt_abort_i;
  logic mst_busy_o, mst_done_o, discard_o;
  logic [3:0] mst_cmd_i, mst_be_i, slot_busy_o;
  logic [31:0] mst_addr_i, mst_wdata_i, mst_rdata_o;
  logic [1:0] mst_resp_o;
  int bad_count = 0;
  int checked = 0;
  int discards = 0;

  // Clock
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // Ends and checker
  dtx_if bus_if ();
  dtx_bridge #(.NSLOT(4), .PMW_DEPTH(4), .DISCARD_CLKS(64)) dtx_bridge_i (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .bus(bus_if),
    .slot_busy_o(slot_busy_o), .discard_o(discard_o));
  dtx_far_end dtx_far_end_i (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .bus(bus_if),
    .mst_req_i(mst_req_i), .mst_cmd_i(mst_cmd_i), .mst_addr_i(mst_addr_i),
    .mst_be_i(mst_be_i), .mst_wdata_i(mst_wdata_i), .mst_busy_o(mst_busy_o),
    .mst_done_o(mst_done_o), .mst_resp_o(mst_resp_o), .mst_rdata_o(mst_rdata_o),
    .tgt_retry_i(tgt_retry_i), .tgt_abort_i(tgt_abort_i));
  dtx_assertions dtx_assertions_i (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .orig_req(bus_if.orig_req), .orig_cmd(bus_if.orig_cmd), .orig_ack(bus_if.orig_ack),
    .orig_resp(bus_if.orig_resp), .orig_rdata(bus_if.orig_rdata),
    .dst_req(bus_if.dst_req), .dst_posted(bus_if.dst_posted), .dst_cmd(bus_if.dst_cmd),
    .dst_addr(bus_if.dst_addr), .dst_ack(bus_if.dst_ack), .dst_resp(bus_if.dst_resp));

  // Counts completion timeouts, sampled away from the launching edge
  always @(negedge sys_clk_i) begin
    if (discard_o === 1'b1) discards++;
  end

  // Verdict and end of run
  task automatic print_verdict();
    $display("counts: %0d checks, %0d mismatches", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // Hands one request to the far-end master
  task automatic start_txn(input logic [3:0] c, input logic [31:0] a, input logic [3:0] be,
                           input logic [31:0] wd);
    @(negedge sys_clk_i);
    mst_req_i = 1'b1;
    mst_cmd_i = c;
    mst_addr_i = a;
    mst_be_i = be;
    mst_wdata_i = wd;
    @(negedge sys_clk_i);
    mst_req_i = 1'b0;
  endtask : start_txn

  // Waits for completion and judges status and data
  task automatic wait_done(input logic [1:0] er, input logic [31:0] ed, input bit cd,
                           input string m);
    int n;
    n = 0;
    while (mst_done_o !== 1'b1 && n < 600) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n >= 600) begin
      bad_count++;
      $display("mismatch at %0t ns: %s timed out", $time, m);
      print_verdict();
    end else begin
      `chk(mst_resp_o, er, m)
      if (cd) `chk(mst_rdata_o, ed, m)
    end
  endtask : wait_done

  task automatic run(input logic [3:0] c, input logic [31:0] a, input logic [3:0] be,
                     input logic [31:0] wd, input logic [1:0] er, input bit cd, input string m);
    start_txn(c, a, be, wd);
    wait_done(er, wd, cd, m);
  endtask : run

  // Posted writes, then reads that must see them
  task automatic t_post_read();
    run(4'h7, 32'h0000_0010, 4'hF, 32'hA5A5_5A5A, 2'h0, 0, "posted write");
    run(4'h6, 32'h0000_0010, 4'hF, 32'hA5A5_5A5A, 2'h0, 1, "read after write");
    run(4'hF, 32'h0000_0014, 4'hF, 32'h3C3C_C3C3, 2'h0, 0, "invalidate write");
    run(4'hE, 32'h0000_0014, 4'hF, 32'h3C3C_C3C3, 2'h0, 1, "read line");
    run(4'h7, 32'h0000_0014, 4'h1, 32'hFFFF_FFAA, 2'h0, 0, "byte write");
    run(4'hC, 32'h0000_0014, 4'hF, 32'h3C3C_C3AA, 2'h0, 1, "read multiple");
    $display("test post_read done");
  endtask : t_post_read

  // Posted writes to one word land in arrival order
  task automatic t_order();
    for (int i = 0; i < 4; i++) begin
      run(4'h7, 32'h0000_0020, 4'hF, 32'h0000_1000 + i, 2'h0, 0, "queued write");
    end
    run(4'h6, 32'h0000_0020, 4'hF, 32'h0000_1003, 2'h0, 1, "last write wins");
    $display("test order done");
  endtask : t_order

  // I/O and configuration writes are delayed, then read back
  task automatic t_delayed_wr();
    run(4'h3, 32'h0000_0040, 4'hF, 32'h1234_5678, 2'h0, 0, "io write");
    run(4'hA, 32'h0000_0040, 4'hF, 32'h1234_5678, 2'h0, 1, "cfg read");
    run(4'hB, 32'h0000_0044, 4'hF, 32'h9ABC_DEF0, 2'h0, 0, "cfg write");
    run(4'h2, 32'h0000_0044, 4'hF, 32'h9ABC_DEF0, 2'h0, 1, "io read");
    $display("test delayed_wr done");
  endtask : t_delayed_wr

  // Target keeps retrying: request stays latched until it completes
  task automatic t_retry();
    run(4'h7, 32'h0000_0050, 4'hF, 32'h5555_AAAA, 2'h0, 0, "setup write");
    repeat (10) @(negedge sys_clk_i);
    tgt_retry_i = 1'b1;
    start_txn(4'h6, 32'h0000_0050, 4'hF, 32'h5555_AAAA);
    repeat (40) @(posedge sys_clk_i);
    #1;
    `chk(mst_busy_o, 1'b1, "master finished under retry")
    `chk(slot_busy_o !== 4'h0, 1'b1, "slot lost under retry")
    @(negedge sys_clk_i);
    tgt_retry_i = 1'b0;
    wait_done(2'h0, 32'h5555_AAAA, 1, "read after retries");
    repeat (3) @(posedge sys_clk_i);
    #1;
    `chk(slot_busy_o, 4'h0, "slot not retired")
    $display("test retry done");
  endtask : t_retry

  // Abort status is handed back; memory writes still accepted
  task automatic t_abort();
    @(negedge sys_clk_i);
    tgt_abort_i = 1'b1;
    run(4'h2, 32'h0000_0060, 4'hF, 32'h0000_0000, 2'h3, 0, "aborted read");
    run(4'hB, 32'h0000_0060, 4'hF, 32'h0000_0001, 2'h3, 0, "aborted write");
    run(4'h7, 32'h0000_0060, 4'hF, 32'h0000_0002, 2'h0, 0, "write under abort");
    @(negedge sys_clk_i);
    tgt_abort_i = 1'b0;
    run(4'h0, 32'h0000_0060, 4'hF, 32'h0000_0000, 2'h2, 0, "unknown command");
    $display("test abort done");
  endtask : t_abort

  // Reset in mid-run frees latched slots
  task automatic t_reset();
    @(negedge sys_clk_i);
    tgt_retry_i = 1'b1;
    start_txn(4'h6, 32'h0000_0010, 4'hF, 32'h0000_0000);
    repeat (6) @(negedge sys_clk_i);
    reset_n_i = 1'b0;
    tgt_retry_i = 1'b0;
    @(negedge sys_clk_i);
    `chk(slot_busy_o, 4'h0, "slots kept in reset")
    `chk(mst_busy_o, 1'b0, "master busy in reset")
    reset_n_i = 1'b1;
    run(4'h6, 32'h0000_0010, 4'hF, 32'hA5A5_5A5A, 2'h0, 1, "read after reset");
    `chk(discards, 0, "completion dropped while master repeats")
    $display("test reset done");
  endtask : t_reset

  // Main sequence
  initial begin
    reset_n_i = 1'b0;
    mst_req_i = 1'b0;
    mst_cmd_i = 4'h0;
    mst_addr_i = 32'h0000_0000;
    mst_be_i = 4'h0;
    mst_wdata_i = 32'h0000_0000;
    tgt_retry_i = 1'b0;
    tgt_abort_i = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    t_post_read();
    t_order();
    t_delayed_wr();
    t_retry();
    t_abort();
    t_reset();
    print_verdict();
  end
endmodule : delayed_transaction_ordering_test
`default_nettype wire
